// ### design/exec_pkg.sv
// Purpose: shared constants and types of the flag, branch, bit and shift executor
// Assumes: Avalon-MM slave with 32-bit data and byte addresses
// Notes: status flag bit order is C Z N V S H T I from bit 0 upward
package exec_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_PC = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_INFO = 8'h0C;
  localparam logic [7:0] OFS_GPR_SEL = 8'h10;
  localparam logic [7:0] OFS_GPR_DATA = 8'h14;
  localparam logic [7:0] OFS_IO_SEL = 8'h18;
  localparam logic [7:0] OFS_IO_DATA = 8'h1C;

  // status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  typedef enum logic [5:0] {
    OP_NOP = 6'h00,
    OP_BR_SET = 6'h01,
    OP_BR_CLR = 6'h02,
    OP_BR_LESS = 6'h03,
    OP_IO_SET = 6'h04,
    OP_IO_CLR = 6'h05,
    OP_LSL = 6'h06,
    OP_LSR = 6'h07,
    OP_ROR = 6'h08,
    OP_ASR = 6'h09,
    OP_SWAP = 6'h0A,
    OP_FLAG_SET = 6'h0B,
    OP_FLAG_CLR = 6'h0C,
    OP_BST = 6'h0D,
    OP_BLD = 6'h0E,
    OP_MOV = 6'h0F,
    OP_REG_PAIR_COPY = 6'h10
  } op_t;

  // command word layout, msb first
  typedef struct packed {
    logic [4:0] rsvd3;
    logic [2:0] bitsel;
    logic rsvd2;
    logic [6:0] src;
    logic [2:0] rsvd1;
    logic [4:0] dst;
    logic [1:0] rsvd0;
    logic [5:0] op;
  } cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_EXEC2 = 2'b11,
    ST_ACK = 2'b10
  } state_t;

  typedef struct packed {
    logic [7:0] result;
    logic [7:0] flags;
    logic taken;
  } unit_out_t;

  typedef struct packed {
    state_t st;
    logic wreq;
    logic [31:0] rdata;
    cmd_t cmd;
    logic [15:0] pc;
    logic [7:0] flags;
    logic [4:0] gpr_sel;
    logic [4:0] io_sel;
    logic [1:0] cycles;
    logic bad;
  } core_t;

  localparam core_t CORE_RESET = '{st: ST_IDLE, wreq: 1'b1, rdata: 32'h0000_0000,
    cmd: '0, pc: PC_RESET, flags: FLAGS_RESET, gpr_sel: 5'h00, io_sel: 5'h00,
    cycles: 2'h0, bad: 1'b0};

endpackage

// ### design/bank_mem.sv
// Purpose: small byte-lane memory with two registered read ports
// Assumes: one write port, byte enables per lane
// Notes: read data show the word addressed on the previous edge
`timescale 1ns/1ns
module bank_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4,
  parameter int LANES = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [LANES-1:0] i_be,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [8*LANES-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr_a,
  input wire logic [AW-1:0] i_raddr_b,
  output logic [8*LANES-1:0] o_rdata_a,
  output logic [8*LANES-1:0] o_rdata_b
);

  logic [8*LANES-1:0] mem [DEPTH];

  always_ff @(posedge i_ref_clk) begin
    for (int g = 0; g < LANES; g++) begin
      if (i_we && i_be[g]) begin
        mem[i_waddr][8*g +: 8] <= i_wdata[8*g +: 8];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rdata_a <= '0;
      o_rdata_b <= '0;
    end else begin
      o_rdata_a <= mem[i_raddr_a];
      o_rdata_b <= mem[i_raddr_b];
    end
  end

endmodule // bank_mem

// ### design/bit_shift_unit.sv
// Purpose: shift, rotate, bit transfer, flag and branch-condition logic
// Assumes: purely combinational, operands already selected
// Notes: flags pass through unchanged for ops that do not touch them
`timescale 1ns/1ns
module bit_shift_unit
  import exec_pkg::*;
(
  input wire logic [5:0] i_op,
  input wire logic [7:0] i_rd,
  input wire logic [7:0] i_rr,
  input wire logic [2:0] i_bit,
  input wire logic [7:0] i_flags,
  output unit_out_t o_out
);

  logic shift_op;
  logic carry;

  always_comb begin
    o_out = '{result: i_rd, flags: i_flags, taken: 1'b0};
    shift_op = 1'b1;
    carry = i_rd[0];
    case (op_t'(i_op))
      OP_LSL: begin
        o_out.result = {i_rd[6:0], 1'b0};
        carry = i_rd[7];
      end
      OP_LSR: o_out.result = {1'b0, i_rd[7:1]};
      OP_ROR: o_out.result = {i_flags[FLAG_C], i_rd[7:1]};
      OP_ASR: o_out.result = {i_rd[7], i_rd[7:1]};
      default: shift_op = 1'b0;
    endcase
    if (shift_op) begin
      // zero, carry, negative, overflow = n xor c
      o_out.flags[FLAG_Z] = (o_out.result == 8'h00);
      o_out.flags[FLAG_C] = carry;
      o_out.flags[FLAG_N] = o_out.result[7];
      o_out.flags[FLAG_V] = o_out.result[7] ^ carry;
    end
    case (op_t'(i_op))
      OP_SWAP: o_out.result = {i_rd[3:0], i_rd[7:4]};
      OP_BLD: o_out.result[i_bit] = i_flags[FLAG_T];
      OP_BST: o_out.flags[FLAG_T] = i_rr[i_bit];
      OP_FLAG_SET: o_out.flags[i_bit] = 1'b1;
      OP_FLAG_CLR: o_out.flags[i_bit] = 1'b0;
      OP_BR_SET: o_out.taken = i_flags[i_bit];
      OP_BR_CLR: o_out.taken = ~i_flags[i_bit];
      OP_BR_LESS: o_out.taken = i_flags[FLAG_N] ^ i_flags[FLAG_V];
      default: o_out.taken = 1'b0;
    endcase
  end

endmodule // bit_shift_unit

// ### design/flag_branch_bit_shift_exec.sv
// Purpose: executes branch, bit, shift and flag commands written over Avalon-MM
// Assumes: one command at a time; waitrequest holds the command write until done
// Notes: general registers kept as 16 pairs, I/O space as 32 bytes
`timescale 1ns/1ns

// How it works
// - branch on half carry set or clear adds k plus one to pc, 1 cycle untaken, 2 taken.
// - branch on transfer flag set or clear adds k plus one, leaves flags, 1 or 2 cycles.
// - branch on overflow set or clear adds k plus one, leaves flags, 1 or 2 cycles.
// - branch on interrupt enable set or clear adds k plus one, leaves flags, 1 or 2 cycles.
// - io bit set forces bit b of io register p high, others kept, no flags, 2 cycles.
// - io bit clear forces bit b of io register p low, others kept, no flags, 2 cycles.
// - left shift moves each bit up, loads 0 at bit 0, updates z c n v in 1 cycle.
// - right shift moves each bit down, loads 0 at bit 7, updates z c n v in 1 cycle.
// - rotate right puts old carry in bit 7 and old bit 0 in carry, z c n v, 1 cycle.
// - arithmetic right shift keeps bit 7 and moves the rest down, z c n v, 1 cycle.
// - flag set by index forces exactly one status flag high in 1 cycle.
// - flag clear by index forces exactly one status flag low in 1 cycle.
// - bit store copies bit b of the source register into the transfer flag only.
// - bit load writes the transfer flag into bit b of rd, no flags, 1 cycle.
module flag_branch_bit_shift_exec
  import exec_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic [7:0] o_status_flags,
  output logic [15:0] o_pc
);

  core_t s_q;
  core_t s_d;
  cmd_t wcmd;
  unit_out_t u_out;
  logic gpr_we;
  logic [1:0] gpr_be;
  logic [3:0] gpr_waddr;
  logic [15:0] gpr_wdata;
  logic [3:0] gpr_ra;
  logic [3:0] gpr_rb;
  logic [15:0] gpr_rdata_a;
  logic [15:0] gpr_rdata_b;
  logic io_we;
  logic [4:0] io_waddr;
  logic [7:0] io_wdata;
  logic [4:0] io_ra;
  logic [7:0] io_rdata;
  logic [7:0] rd_byte;
  logic [7:0] rr_byte;
  logic [7:0] bmask;
  logic [15:0] kext;
  logic in_exec;

  assign rd_byte = s_q.cmd.dst[0] ? gpr_rdata_a[15:8] : gpr_rdata_a[7:0];
  assign rr_byte = s_q.cmd.src[0] ? gpr_rdata_b[15:8] : gpr_rdata_b[7:0];
  assign bmask = 8'h01 << s_q.cmd.bitsel;
  assign kext = {{9{s_q.cmd.src[6]}}, s_q.cmd.src};
  assign in_exec = (s_q.st == ST_EXEC);
  assign wcmd = i_writedata;

  bank_mem #(.DEPTH(16), .AW(4), .LANES(2)) u_gpr (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_we(gpr_we),
    .i_be(gpr_be),
    .i_waddr(gpr_waddr),
    .i_wdata(gpr_wdata),
    .i_raddr_a(gpr_ra),
    .i_raddr_b(gpr_rb),
    .o_rdata_a(gpr_rdata_a),
    .o_rdata_b(gpr_rdata_b)
  );

  bank_mem #(.DEPTH(32), .AW(5), .LANES(1)) u_io (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_we(io_we),
    .i_be(1'b1),
    .i_waddr(io_waddr),
    .i_wdata(io_wdata),
    .i_raddr_a(io_ra),
    .i_raddr_b(5'h00),
    .o_rdata_a(io_rdata),
    .o_rdata_b()
  );

  bit_shift_unit u_unit (
    .i_op(s_q.cmd.op),
    .i_rd(rd_byte),
    .i_rr(rr_byte),
    .i_bit(s_q.cmd.bitsel),
    .i_flags(s_q.flags),
    .o_out(u_out)
  );

  always_comb begin
    s_d = s_q;
    gpr_ra = s_q.gpr_sel[4:1];
    gpr_rb = s_q.cmd.src[4:1];
    io_ra = s_q.io_sel;
    gpr_we = 1'b0;
    gpr_be = s_q.cmd.dst[0] ? 2'b10 : 2'b01;
    gpr_waddr = s_q.cmd.dst[4:1];
    gpr_wdata = {2{u_out.result}};
    io_we = 1'b0;
    io_waddr = s_q.cmd.dst;
    // read-modify-write keeps the other bits of the io byte
    io_wdata = (s_q.cmd.op == OP_IO_SET) ? (io_rdata | bmask) : (io_rdata & ~bmask);
    if (s_q.st == ST_EXEC || s_q.st == ST_EXEC2) begin
      gpr_ra = s_q.cmd.dst[4:1];
      io_ra = s_q.cmd.dst;
    end
    case (s_q.st)
      ST_IDLE: begin
        if (i_write) begin
          s_d.st = ST_ACK;
          s_d.wreq = 1'b0;
          case (i_address)
            OFS_CMD: begin
              if (i_byteenable[0]) begin
                s_d.cmd = wcmd;
                s_d.st = ST_EXEC;
                s_d.wreq = 1'b1;
                s_d.bad = 1'b0;
                gpr_ra = wcmd.dst[4:1];
                gpr_rb = wcmd.src[4:1];
                io_ra = wcmd.dst;
              end
            end
            OFS_PC: begin
              s_d.pc = {i_byteenable[1] ? i_writedata[15:8] : s_q.pc[15:8],
                        i_byteenable[0] ? i_writedata[7:0] : s_q.pc[7:0]};
            end
            OFS_FLAGS: if (i_byteenable[0]) s_d.flags = i_writedata[7:0];
            OFS_GPR_SEL: if (i_byteenable[0]) s_d.gpr_sel = i_writedata[4:0];
            OFS_GPR_DATA: begin
              gpr_we = i_byteenable[0];
              gpr_be = s_q.gpr_sel[0] ? 2'b10 : 2'b01;
              gpr_waddr = s_q.gpr_sel[4:1];
              gpr_wdata = {2{i_writedata[7:0]}};
            end
            OFS_IO_SEL: if (i_byteenable[0]) s_d.io_sel = i_writedata[4:0];
            OFS_IO_DATA: begin
              io_we = i_byteenable[0];
              io_waddr = s_q.io_sel;
              io_wdata = i_writedata[7:0];
            end
            default: s_d.st = ST_ACK;
          endcase
        end else if (i_read) begin
          s_d.st = ST_ACK;
          s_d.wreq = 1'b0;
          case (i_address)
            OFS_CMD: s_d.rdata = s_q.cmd;
            OFS_PC: s_d.rdata = {16'h0000, s_q.pc};
            OFS_FLAGS: s_d.rdata = {24'h00_0000, s_q.flags};
            OFS_INFO: s_d.rdata = {23'h00_0000, s_q.bad, 6'h00, s_q.cycles};
            OFS_GPR_SEL: s_d.rdata = {27'h000_0000, s_q.gpr_sel};
            OFS_GPR_DATA: begin
              s_d.rdata = {24'h00_0000,
                           s_q.gpr_sel[0] ? gpr_rdata_a[15:8] : gpr_rdata_a[7:0]};
            end
            OFS_IO_SEL: s_d.rdata = {27'h000_0000, s_q.io_sel};
            OFS_IO_DATA: s_d.rdata = {24'h00_0000, io_rdata};
            default: s_d.rdata = 32'h0000_0000;
          endcase
        end
      end
      ST_EXEC: begin
        s_d.st = ST_ACK;
        s_d.wreq = 1'b0;
        s_d.cycles = CYC_ONE;
        s_d.pc = s_q.pc + 16'h0001;
        case (op_t'(s_q.cmd.op))
          OP_BR_SET, OP_BR_CLR, OP_BR_LESS: begin
            if (u_out.taken) begin
              s_d.st = ST_EXEC2;
              s_d.wreq = 1'b1;
              s_d.cycles = CYC_TWO;
              s_d.pc = s_q.pc;
            end
          end
          OP_IO_SET, OP_IO_CLR: begin
            s_d.st = ST_EXEC2;
            s_d.wreq = 1'b1;
            s_d.cycles = CYC_TWO;
            s_d.pc = s_q.pc;
          end
          OP_LSL, OP_LSR, OP_ROR, OP_ASR, OP_SWAP, OP_BLD: begin
            gpr_we = 1'b1;
            s_d.flags = u_out.flags;
          end
          OP_FLAG_SET, OP_FLAG_CLR, OP_BST: s_d.flags = u_out.flags;
          OP_MOV: begin
            gpr_we = 1'b1;
            gpr_wdata = {2{rr_byte}};
          end
          OP_REG_PAIR_COPY: begin
            gpr_we = 1'b1;
            gpr_be = 2'b11;
            gpr_wdata = gpr_rdata_b;
          end
          OP_NOP: s_d.bad = 1'b0;
          default: s_d.bad = 1'b1;
        endcase
      end
      ST_EXEC2: begin
        s_d.st = ST_ACK;
        s_d.wreq = 1'b0;
        if (s_q.cmd.op == OP_IO_SET || s_q.cmd.op == OP_IO_CLR) begin
          io_we = 1'b1;
          s_d.pc = s_q.pc + 16'h0001;
        end else begin
          s_d.pc = s_q.pc + kext + 16'h0001;
        end
      end
      ST_ACK: begin
        s_d.st = ST_IDLE;
        s_d.wreq = 1'b1;
      end
      default: s_d = CORE_RESET;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_q <= CORE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_readdata = s_q.rdata;
  assign o_waitrequest = s_q.wreq;
  assign o_status_flags = s_q.flags;
  assign o_pc = s_q.pc;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  AST_BR_TAKEN: assert property (
    in_exec && s_q.cmd.op inside {OP_BR_SET, OP_BR_CLR, OP_BR_LESS} && u_out.taken
    |=> s_q.st == ST_EXEC2 ##1 (s_q.st == ST_ACK && s_q.pc == $past(s_q.pc, 2) + $past(kext, 2)
      + 16'h0001 && s_q.flags == $past(s_q.flags, 2)))
    else $error("taken branch target or timing wrong");
  AST_BR_UNTAKEN: assert property (
    in_exec && s_q.cmd.op inside {OP_BR_SET, OP_BR_CLR, OP_BR_LESS} && !u_out.taken
    |=> s_q.st == ST_ACK && s_q.pc == $past(s_q.pc) + 16'h0001 && s_q.flags == $past(s_q.flags))
    else $error("untaken branch wrong");
  AST_BR_COND: assert property (
    in_exec |-> (s_q.cmd.op != OP_BR_LESS || u_out.taken == (s_q.flags[FLAG_N] ^ s_q.flags[FLAG_V]))
      && (s_q.cmd.op != OP_BR_SET || u_out.taken == s_q.flags[s_q.cmd.bitsel]))
    else $error("branch condition wrong");
  AST_IO_BIT: assert property (
    s_q.st == ST_EXEC2 && s_q.cmd.op inside {OP_IO_SET, OP_IO_CLR}
    |-> io_we && io_waddr == s_q.cmd.dst && ((io_wdata ^ io_rdata) & ~bmask) == 8'h00
      && (io_wdata & bmask) == ((s_q.cmd.op == OP_IO_SET) ? bmask : 8'h00) && $stable(s_q.flags))
    else $error("io bit write wrong");
  AST_SHIFT_LEFT: assert property (
    in_exec && s_q.cmd.op inside {OP_LSL, OP_LSR} |-> gpr_we && u_out.flags[FLAG_C]
      == ((s_q.cmd.op == OP_LSL) ? rd_byte[7] : rd_byte[0]) && u_out.result
      == ((s_q.cmd.op == OP_LSL) ? {rd_byte[6:0], 1'b0} : {1'b0, rd_byte[7:1]}))
    else $error("logical shift wrong");
  AST_SHIFT_RIGHT: assert property (
    in_exec && s_q.cmd.op inside {OP_ROR, OP_ASR} |=> s_q.st == ST_ACK
      && s_q.flags[FLAG_C] == $past(rd_byte[0]) && s_q.flags[FLAG_Z] == ($past(u_out.result) == 8'h00)
      && s_q.flags[FLAG_V] == ($past(u_out.result[7]) ^ $past(rd_byte[0])))
    else $error("right shift flags wrong");
  AST_FLAG_ONE: assert property (
    in_exec && s_q.cmd.op inside {OP_FLAG_SET, OP_FLAG_CLR} |=> s_q.flags
      == (($past(s_q.cmd.op) == OP_FLAG_SET) ? ($past(s_q.flags) | $past(bmask))
        : ($past(s_q.flags) & ~$past(bmask))))
    else $error("single flag update wrong");
  AST_BIT_STORE: assert property (
    in_exec && s_q.cmd.op == OP_BST |=> s_q.flags[FLAG_T] == ($past(rr_byte & bmask) != 8'h00)
      && ((s_q.flags ^ $past(s_q.flags)) & 8'hBF) == 8'h00)
    else $error("bit store wrong");
  AST_BIT_LOAD: assert property (
    in_exec && s_q.cmd.op == OP_BLD |-> gpr_we && ((u_out.result ^ rd_byte) & ~bmask) == 8'h00
      && ((u_out.result & bmask) != 8'h00) == s_q.flags[FLAG_T] && u_out.flags == s_q.flags)
    else $error("bit load wrong");
  AST_COPY: assert property (
    in_exec && s_q.cmd.op == OP_MOV |-> gpr_we && gpr_wdata[7:0] == rr_byte
      && gpr_waddr == s_q.cmd.dst[4:1])
    else $error("register copy wrong");

  COV_BR_TAKEN: cover property (in_exec && s_q.cmd.op == OP_BR_SET && u_out.taken);
  COV_IO_SET: cover property (s_q.st == ST_EXEC2 && s_q.cmd.op == OP_IO_SET);
  COV_ROR: cover property (in_exec && s_q.cmd.op == OP_ROR && s_q.flags[FLAG_C]);
  COV_REG_PAIR_COPY: cover property (in_exec && s_q.cmd.op == OP_REG_PAIR_COPY);

endmodule // flag_branch_bit_shift_exec

// ### test/flag_branch_bit_shift_exec_test.sv
// Purpose: self-checking bench of the branch, bit, shift and flag executor
// Assumes: avalon master held until waitrequest low; registers written before use
// Notes: expected values worked out here from the command rules
`timescale 1ns/1ns
module flag_branch_bit_shift_exec_test;
  import exec_pkg::*;
  logic i_ref_clk;
  logic i_rst;
  logic [7:0] i_address;
  logic i_read;
  logic i_write;
  logic [31:0] i_writedata;
  logic [3:0] i_byteenable;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic [7:0] o_status_flags;
  logic [15:0] o_pc;
  int err_count;
  int compares;
  int ncyc;
  logic [31:0] rdv;

  flag_branch_bit_shift_exec dut (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_address(i_address),
    .i_read(i_read),
    .i_write(i_write),
    .i_writedata(i_writedata),
    .i_byteenable(i_byteenable),
    .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest),
    .o_status_flags(o_status_flags),
    .o_pc(o_pc)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one avalon transfer; ncyc counts edges up to acceptance
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_ref_clk);
    i_address <= a;
    i_writedata <= d;
    i_write <= wr;
    i_read <= !wr;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    if (o_waitrequest !== 1'b0) begin
      err_count++;
      $display("[ERR] waitrequest expected 0 seen %b", o_waitrequest);
      end_of_test();
    end
    rdv = o_readdata;
    ncyc = n;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic exec(input logic [5:0] op, input logic [4:0] dst, input logic [6:0] src,
                      input logic [2:0] b);
    cmd_t c;
    c = '0;
    c.op = op;
    c.dst = dst;
    c.src = src;
    c.bitsel = b;
    bus(1'b1, OFS_CMD, c);
  endtask

  task automatic set_reg(input logic [4:0] idx, input logic [7:0] v);
    wr(OFS_GPR_SEL, {27'h0, idx});
    wr(OFS_GPR_DATA, {24'h0, v});
  endtask

  task automatic get_reg(input logic [4:0] idx);
    wr(OFS_GPR_SEL, {27'h0, idx});
    bus(1'b0, OFS_GPR_DATA, 32'h0);
  endtask

  task automatic t_branch();
    logic [2:0] sel [4];
    logic [7:0] fv;
    logic [6:0] k;
    logic tk;
    sel = '{3'h5, 3'h6, 3'h3, 3'h7};
    for (int i = 0; i < 4; i++) begin
      for (int f = 0; f < 2; f++) begin
        for (int o = 0; o < 2; o++) begin
          fv = f ? (8'h01 << sel[i]) : ~(8'h01 << sel[i]);
          k = f ? 7'h40 : 7'h3F;
          tk = (o == 0) == (f == 1);
          wr(OFS_FLAGS, {24'h0, fv});
          wr(OFS_PC, 32'h0000_0100);
          exec(o ? OP_BR_CLR : OP_BR_SET, 5'h00, k, sel[i]);
          check("br cyc", ncyc, tk ? 4 : 3);
          check("br pc", o_pc, tk ? 16'(16'h0101 + {{9{k[6]}}, k}) : 16'h0101);
          check("br flags", o_status_flags, fv);
        end
      end
    end
    for (int nv = 0; nv < 4; nv++) begin
      tk = (nv == 1) || (nv == 2);
      wr(OFS_FLAGS, 32'(nv) << 2);
      wr(OFS_PC, 32'h0000_0200);
      exec(OP_BR_LESS, 5'h00, 7'h05, 3'h0);
      check("less pc", o_pc, tk ? 16'h0206 : 16'h0201);
    end
  endtask

  task automatic t_io();
    wr(OFS_FLAGS, 32'h0000_005A);
    wr(OFS_IO_SEL, 32'h0000_001F);
    wr(OFS_IO_DATA, 32'h0000_00A5);
    exec(OP_IO_SET, 5'h1F, 7'h00, 3'h1);
    check("io set cyc", ncyc, 4);
    bus(1'b0, OFS_IO_DATA, 32'h0);
    check("io set", rdv[7:0], 8'hA7);
    exec(OP_IO_CLR, 5'h1F, 7'h00, 3'h7);
    check("io clr cyc", ncyc, 4);
    bus(1'b0, OFS_IO_DATA, 32'h0);
    check("io clr", rdv[7:0], 8'h27);
    bus(1'b0, OFS_INFO, 32'h0);
    check("io info cyc", rdv[1:0], CYC_TWO);
    check("io flags", o_status_flags, 8'h5A);
  endtask

  task automatic t_shift();
    op_t ops [8];
    logic [7:0] vals [8];
    logic [7:0] r;
    logic [7:0] fin;
    logic c;
    logic cin;
    ops = '{OP_LSL, OP_LSL, OP_LSR, OP_LSR, OP_ROR, OP_ROR, OP_ASR, OP_ASR};
    vals = '{8'h80, 8'h41, 8'h01, 8'hFE, 8'h01, 8'h02, 8'h81, 8'h01};
    for (int i = 0; i < 8; i++) begin
      cin = i[0];
      fin = {7'h7F, cin};
      case (ops[i])
        OP_LSL: {c, r} = {vals[i], 1'b0};
        OP_LSR: {r, c} = {1'b0, vals[i]};
        OP_ROR: {r, c} = {cin, vals[i]};
        default: {r, c} = {vals[i][7], vals[i]};
      endcase
      set_reg(5'h06, vals[i]);
      wr(OFS_FLAGS, {24'h0, fin});
      exec(ops[i], 5'h06, 7'h00, 3'h0);
      check("sh cyc", ncyc, 3);
      check("sh flags", o_status_flags, {fin[7:4], r[7] ^ c, r[7], r == 8'h00, c});
      get_reg(5'h06);
      check("sh data", rdv[7:0], r);
    end
  endtask

  task automatic t_flags();
    for (int s = 0; s < 8; s++) begin
      wr(OFS_FLAGS, 32'h0);
      exec(OP_FLAG_SET, 5'h00, 7'h00, 3'(s));
      check("fset cyc", ncyc, 3);
      check("fset", o_status_flags, 8'h01 << s);
      wr(OFS_FLAGS, 32'h0000_00FF);
      exec(OP_FLAG_CLR, 5'h00, 7'h00, 3'(s));
      check("fclr cyc", ncyc, 3);
      check("fclr", o_status_flags, 8'(~(8'h01 << s)));
    end
  endtask

  task automatic t_bits();
    set_reg(5'h03, 8'h10);
    wr(OFS_FLAGS, 32'h0000_00BF);
    exec(OP_BST, 5'h00, 7'h03, 3'h4);
    check("bst cyc", ncyc, 3);
    check("bst one", o_status_flags, 8'hFF);
    exec(OP_BST, 5'h00, 7'h03, 3'h3);
    check("bst zero", o_status_flags, 8'hBF);
    set_reg(5'h07, 8'hFF);
    exec(OP_BLD, 5'h07, 7'h00, 3'h0);
    check("bld cyc", ncyc, 3);
    check("bld flags", o_status_flags, 8'hBF);
    get_reg(5'h07);
    check("bld zero", rdv[7:0], 8'hFE);
    set_reg(5'h08, 8'h00);
    wr(OFS_FLAGS, 32'h0000_0040);
    exec(OP_BLD, 5'h08, 7'h00, 3'h7);
    get_reg(5'h08);
    check("bld one", rdv[7:0], 8'h80);
  endtask

  task automatic t_moves();
    set_reg(5'h02, 8'h3C);
    wr(OFS_FLAGS, 32'h0000_005A);
    exec(OP_SWAP, 5'h02, 7'h00, 3'h0);
    check("swap cyc", ncyc, 3);
    exec(OP_MOV, 5'h09, 7'h02, 3'h0);
    check("mov cyc", ncyc, 3);
    get_reg(5'h09);
    check("swap mov", rdv[7:0], 8'hC3);
    set_reg(5'h04, 8'h11);
    set_reg(5'h05, 8'h22);
    exec(OP_REG_PAIR_COPY, 5'h0A, 7'h04, 3'h0);
    check("reg_pair_copy cyc", ncyc, 3);
    get_reg(5'h0A);
    check("reg_pair_copy lo", rdv[7:0], 8'h11);
    get_reg(5'h0B);
    check("reg_pair_copy hi", rdv[7:0], 8'h22);
    check("move flags", o_status_flags, 8'h5A);
  endtask

  task automatic t_misc();
    wr(8'h24, 32'hFFFF_FFFF);
    bus(1'b0, 8'h24, 32'h0);
    check("unmapped", rdv, 32'h0);
    wr(OFS_PC, 32'h0000_0010);
    exec(6'h3F, 5'h00, 7'h00, 3'h0);
    check("bad op pc", o_pc, 16'h0011);
    bus(1'b0, OFS_INFO, 32'h0);
    check("bad op flag", rdv[8], 1'b1);
    exec(OP_NOP, 5'h00, 7'h00, 3'h0);
    check("nop cyc", ncyc, 3);
    check("nop pc", o_pc, 16'h0012);
    bus(1'b0, OFS_INFO, 32'h0);
    check("nop info", rdv[8:0], {1'b0, 6'h00, CYC_ONE});
  endtask

  initial begin
    i_rst = 1'b1;
    i_address = 8'h00;
    i_read = 1'b0;
    i_write = 1'b0;
    i_writedata = 32'h0;
    i_byteenable = 4'hF;
    err_count = 0;
    compares = 0;
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    check("rst pc", o_pc, PC_RESET);
    check("rst flags", o_status_flags, FLAGS_RESET);
    check("rst wait", o_waitrequest, 1'b1);
    t_branch();
    t_io();
    t_shift();
    t_flags();
    t_bits();
    t_moves();
    t_misc();
    end_of_test();
  end
endmodule // flag_branch_bit_shift_exec_test
